// ==== maint_request_tracker.sv ====
/*
  Maintenance request tracker: AXI4-Lite maintenance slave that routes
  accesses to local configuration space or builds remote maintenance
  request packets, and matches the returning responses by ID.
  Assumes a local config master and packet ports that keep a valid/ready
  handshake, all on ref_clk.
*/
// Behaviour
// [R1] Remote accesses become maintenance request packets sent toward the link.
// [R2] Response returned to user only when its ID matches the outstanding one.
// [R3] Matched read response data is returned on the read data channel.
// [R4] Only 32-bit word accesses exist; no narrower or wider transfer.
// [R5] One read and one write outstanding at most, local or remote.
// [R6] Responses with mismatched ID are dropped silently.
// [R7] Maintenance port reset cancels outstanding read and write requests.
// [R8] Timeout value output mirrors the link timeout register contents.
// [R9] User timeout counter loads from timeout value, expiry asserts reset.
// [R10] User keeps the port idle while asserting the maintenance reset.
// [R11] Maintenance reset clears stored read and write transaction IDs.
// [R12] Late responses to requests from before the reset are dropped.
// [R13] Nonzero top address byte routes remotely, hop count is byte minus one.
// [R14] Request ID starts at zero, increments per remote request, is writable.
// [R15] Source ID from base ID; priority, CRF, destination from info register.
// [R16] Two least significant address bits are ignored.
// [R17] Channel frees when user accepts the matched response.
`timescale 1ns/1ps
`default_nettype none
module maint_request_tracker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic maint_rst,
  input wire logic [31:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [31:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic loc_valid,
  output logic loc_write,
  output logic [23:0] loc_addr,
  output logic [31:0] loc_wdata,
  input wire logic loc_ready,
  input wire logic loc_rsp_valid,
  input wire logic loc_rsp_write,
  input wire logic loc_rsp_err,
  input wire logic [31:0] loc_rsp_data,
  output logic req_valid,
  output logic [3:0] req_ttype,
  output logic [7:0] req_tid,
  output logic [7:0] req_hop,
  output logic [23:0] req_offset,
  output logic [31:0] req_data,
  output logic [15:0] req_src_id,
  output logic [15:0] req_dst_id,
  output logic [1:0] req_prio,
  output logic req_crf,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [3:0] rsp_ttype,
  input wire logic [7:0] rsp_tid,
  input wire logic [3:0] rsp_status,
  input wire logic [31:0] rsp_data,
  input wire logic [15:0] base_dev_id,
  input wire logic [15:0] info_dst_id,
  input wire logic [1:0] info_prio,
  input wire logic info_crf,
  input wire logic info_tid_we,
  input wire logic [7:0] info_tid_wdata,
  output logic [7:0] info_tid,
  input wire logic [23:0] link_timeout_reg,
  output logic [23:0] link_timeout
);
  mrt_chan_if rd_ch();
  mrt_chan_if wr_ch();

  mrt_chan_trk u_rd_trk (
    .ref_clk(ref_clk),
    .rst(rst),
    .maint_rst(maint_rst),
    .ch(rd_ch)
  );
  mrt_chan_trk u_wr_trk (
    .ref_clk(ref_clk),
    .rst(rst),
    .maint_rst(maint_rst),
    .ch(wr_ch)
  );

  logic [7:0] tid_q;
  logic rd_take;
  logic wr_take;
  logic rd_remote;
  logic wr_remote;
  logic req_free;
  logic rsp_rd_hit;
  logic rsp_wr_hit;

  // Requests are only taken when the shared launch stage is empty, so a
  // read and a write in the same cycle are serialised, read first.
  assign req_free = !req_valid && !loc_valid && !maint_rst;
  assign rd_remote = s_araddr[mrt_pkg::HOP_MSB:mrt_pkg::HOP_LSB]
    != mrt_pkg::HOP_LOCAL; // [R13]
  assign wr_remote = s_awaddr[mrt_pkg::HOP_MSB:mrt_pkg::HOP_LSB]
    != mrt_pkg::HOP_LOCAL; // [R13]
  assign rd_take = req_free && s_arvalid && !rd_ch.busy; // [R5]
  assign wr_take = req_free && !rd_take && s_awvalid && s_wvalid
    && !wr_ch.busy; // [R5]

  // A response hits only while its channel still waits on that exact ID.
  assign rsp_rd_hit = rsp_valid && rsp_ttype == mrt_pkg::TT_RD_RSP
    && rd_ch.wait_rsp && rsp_tid == rd_ch.held_tid && !maint_rst; // [R2]
  assign rsp_wr_hit = rsp_valid && rsp_ttype == mrt_pkg::TT_WR_RSP
    && wr_ch.wait_rsp && rsp_tid == wr_ch.held_tid && !maint_rst; // [R2]
  // Everything else on the response port falls through unseen. [R6] [R12]

  assign rd_ch.issue = rd_take;
  assign rd_ch.remote = rd_remote;
  assign rd_ch.tid = tid_q;
  assign rd_ch.rsp_hit = rsp_rd_hit;
  assign rd_ch.done = s_rvalid && s_rready; // [R17]
  assign wr_ch.issue = wr_take;
  assign wr_ch.remote = wr_remote;
  assign wr_ch.tid = tid_q;
  assign wr_ch.rsp_hit = rsp_wr_hit;
  assign wr_ch.done = s_bvalid && s_bready; // [R17]

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_arready <= 1'b0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
    end else begin
      s_arready <= rd_take;
      s_awready <= wr_take;
      s_wready <= wr_take;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tid_q <= mrt_pkg::INFO_TID_RST; // [R14]
    end else if (info_tid_we) begin
      tid_q <= info_tid_wdata; // [R14]
    end else if ((rd_take && rd_remote) || (wr_take && wr_remote)) begin
      tid_q <= tid_q + 8'h01; // [R14]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      info_tid <= mrt_pkg::INFO_TID_RST;
      link_timeout <= 24'h000000;
    end else begin
      info_tid <= tid_q;
      link_timeout <= link_timeout_reg; // [R8]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      req_valid <= 1'b0;
      req_ttype <= mrt_pkg::TT_RD_REQ;
      req_tid <= mrt_pkg::TID_RST;
      req_hop <= 8'h00;
      req_offset <= 24'h000000;
      req_data <= 32'h00000000;
      req_src_id <= 16'h0000;
      req_dst_id <= 16'h0000;
      req_prio <= 2'h0;
      req_crf <= 1'b0;
    end else if (maint_rst) begin
      req_valid <= 1'b0; // [R7]
    end else if ((rd_take && rd_remote) || (wr_take && wr_remote)) begin
      req_valid <= 1'b1; // [R1]
      req_ttype <= rd_take ? mrt_pkg::TT_RD_REQ : mrt_pkg::TT_WR_REQ;
      req_tid <= tid_q;
      req_hop <= rd_take ? s_araddr[31:24] - 8'h01
        : s_awaddr[31:24] - 8'h01; // [R13]
      req_offset <= rd_take ? {s_araddr[23:2], 2'b00}
        : {s_awaddr[23:2], 2'b00}; // [R16]
      req_data <= s_wdata; // [R4]
      req_src_id <= base_dev_id; // [R15]
      req_dst_id <= info_dst_id; // [R15]
      req_prio <= info_prio; // [R15]
      req_crf <= info_crf; // [R15]
    end else if (req_ready) begin
      req_valid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      loc_valid <= 1'b0;
      loc_write <= 1'b0;
      loc_addr <= 24'h000000;
      loc_wdata <= 32'h00000000;
    end else if (maint_rst) begin
      loc_valid <= 1'b0; // [R7]
    end else if ((rd_take && !rd_remote) || (wr_take && !wr_remote)) begin
      loc_valid <= 1'b1;
      loc_write <= !rd_take;
      loc_addr <= rd_take ? {s_araddr[23:2], 2'b00}
        : {s_awaddr[23:2], 2'b00}; // [R16]
      loc_wdata <= s_wdata;
    end else if (loc_ready) begin
      loc_valid <= 1'b0;
    end
  end

  // Local answers need no ID check; they come back while the channel is
  // still busy and not waiting on a remote response.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= mrt_pkg::RESP_OKAY;
    end else if (maint_rst) begin
      s_rvalid <= 1'b0; // [R7]
    end else if (rsp_rd_hit) begin
      s_rvalid <= 1'b1; // [R2]
      s_rdata <= rsp_data; // [R3]
      s_rresp <= rsp_status == mrt_pkg::STAT_DONE ? mrt_pkg::RESP_OKAY
        : mrt_pkg::RESP_SLVERR;
    end else if (loc_rsp_valid && !loc_rsp_write && rd_ch.busy
        && !rd_ch.wait_rsp && !s_rvalid) begin
      s_rvalid <= 1'b1;
      s_rdata <= loc_rsp_data;
      s_rresp <= loc_rsp_err ? mrt_pkg::RESP_SLVERR : mrt_pkg::RESP_OKAY;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_bvalid <= 1'b0;
      s_bresp <= mrt_pkg::RESP_OKAY;
    end else if (maint_rst) begin
      s_bvalid <= 1'b0; // [R7]
    end else if (rsp_wr_hit) begin
      s_bvalid <= 1'b1; // [R2]
      s_bresp <= rsp_status == mrt_pkg::STAT_DONE ? mrt_pkg::RESP_OKAY
        : mrt_pkg::RESP_SLVERR;
    end else if (loc_rsp_valid && loc_rsp_write && wr_ch.busy
        && !wr_ch.wait_rsp && !s_bvalid) begin
      s_bvalid <= 1'b1;
      s_bresp <= loc_rsp_err ? mrt_pkg::RESP_SLVERR : mrt_pkg::RESP_OKAY;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  logic unused_strb;
  assign unused_strb = ^s_wstrb; // Word-only port: byte strobes are ignored
endmodule : maint_request_tracker
`default_nettype wire

// ==== mrt_chan_if.sv ====
/*
  Interface carrying one outstanding-channel tracker's controls and status.
  Assumes one clock shared by the tracker and its owner.
*/
`timescale 1ns/1ps
`default_nettype none
interface mrt_chan_if;
  logic issue;
  logic remote;
  logic [7:0] tid;
  logic rsp_hit;
  logic done;
  logic busy;
  logic wait_rsp;
  logic [7:0] held_tid;
  modport owner(output issue, output remote, output tid, output rsp_hit,
    output done, input busy, input wait_rsp, input held_tid);
  modport trk(input issue, input remote, input tid, input rsp_hit,
    input done, output busy, output wait_rsp, output held_tid);
endinterface : mrt_chan_if
`default_nettype wire

// ==== mrt_chan_trk.sv ====
/*
  Tracks one outstanding access (read or write) and the transaction ID of
  its remote request. Assumes the owner issues only when not busy.
*/
`timescale 1ns/1ps
`default_nettype none
module mrt_chan_trk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic maint_rst,
  mrt_chan_if.trk ch
);
  logic busy_q;
  logic wait_q;
  logic [7:0] tid_q;

  assign ch.busy = busy_q;
  assign ch.wait_rsp = wait_q;
  assign ch.held_tid = tid_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (maint_rst) begin
      busy_q <= 1'b0; // [R7]
    end else if (ch.issue) begin
      busy_q <= 1'b1; // [R5]
    end else if (ch.done) begin
      busy_q <= 1'b0; // [R17]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b0;
    end else if (maint_rst) begin
      wait_q <= 1'b0; // [R7]
    end else if (ch.issue) begin
      wait_q <= ch.remote;
    end else if (ch.rsp_hit) begin
      wait_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tid_q <= mrt_pkg::TID_RST;
    end else if (maint_rst) begin
      tid_q <= mrt_pkg::TID_RST; // [R11]
    end else if (ch.issue && ch.remote) begin
      tid_q <= ch.tid;
    end
  end
endmodule : mrt_chan_trk
`default_nettype wire

// ==== mrt_checker.sv ====
/*
  Port-level assertions for the maintenance request tracker: read path, request ID step and timeout copy.
  Assumes the bind below and a testbench that never overlaps remote reads.
*/
`timescale 1ns/1ps
`default_nettype none
module mrt_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic maint_rst,
  input wire logic [31:0] s_araddr,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic loc_rsp_valid,
  input wire logic req_valid,
  input wire logic [3:0] req_ttype,
  input wire logic [7:0] req_tid,
  input wire logic [7:0] req_hop,
  input wire logic [23:0] req_offset,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [3:0] rsp_ttype,
  input wire logic [7:0] rsp_tid,
  input wire logic [31:0] rsp_data,
  input wire logic [7:0] info_tid,
  input wire logic [23:0] link_timeout_reg,
  input wire logic [23:0] link_timeout
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic wait_q, busy_q, hit;
  logic [7:0] tid_q;
  // Own copy of the read ID so a stuck or stale stored ID shows up
  assign hit = rsp_valid && wait_q && rsp_tid == tid_q &&
    rsp_ttype == mrt_pkg::TT_RD_RSP;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b0;
      tid_q <= 8'h00;
    end else if (maint_rst || hit) begin
      wait_q <= 1'b0;
    end else if (req_valid && req_ready &&
        req_ttype == mrt_pkg::TT_RD_REQ) begin
      wait_q <= 1'b1;
      tid_q <= req_tid;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (maint_rst || (s_rvalid && s_rready)) begin
      busy_q <= 1'b0;
    end else if (s_arready) begin
      busy_q <= 1'b1;
    end
  end
  property p_tmo;
    !$past(rst) |-> link_timeout == $past(link_timeout_reg);
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout copy wrong");
  property p_hop;
    s_arready && s_araddr[31:24] != 8'h00 |-> req_valid &&
      req_ttype == mrt_pkg::TT_RD_REQ &&
      req_hop == s_araddr[31:24] - 8'h01 &&
      req_offset[23:2] == s_araddr[23:2];
  endproperty
  a_hop: assert property (p_hop) else $error("bad remote packet");
  property p_tid;
    $rose(req_valid) |=> info_tid == $past(req_tid) + 8'h01;
  endproperty
  a_tid: assert property (p_tid) else $error("next ID not stepped");
  property p_hold;
    req_valid && !req_ready && !maint_rst |=>
      req_valid && $stable(req_tid) && $stable(req_hop);
  endproperty
  a_hold: assert property (p_hold) else $error("packet not held");
  property p_rdata;
    hit && !maint_rst |=> s_rvalid && s_rdata == $past(rsp_data);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data lost");
  property p_drop;
    rsp_valid && !hit && !loc_rsp_valid && !s_rvalid |=> !s_rvalid;
  endproperty
  a_drop: assert property (p_drop) else $error("stray response");
  property p_mrst;
    maint_rst |=> !req_valid && !s_rvalid;
  endproperty
  a_mrst: assert property (p_mrst) else $error("not cancelled");
  property p_one;
    busy_q |-> !s_arready;
  endproperty
  a_one: assert property (p_one) else $error("second read taken");
  c_hit: cover property (hit);
  c_drop: cover property (rsp_valid && !hit);
  c_mrst: cover property (maint_rst && busy_q);
endmodule : mrt_checker
bind maint_request_tracker mrt_checker mrt_checker_i (.*);
`default_nettype wire

// ==== mrt_far_end.sv ====
/*
  Far side model: remote device answering packets far_lag+1 cycles after accepting them,
  and the local config space. Assumes one request in flight at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module mrt_far_end (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic far_bad,
  input wire logic [7:0] far_lag,
  input wire logic req_valid,
  input wire logic [3:0] req_ttype,
  input wire logic [7:0] req_tid,
  output logic req_ready,
  output logic rsp_valid,
  output logic [3:0] rsp_ttype,
  output logic [7:0] rsp_tid,
  output logic [3:0] rsp_status,
  output logic [31:0] rsp_data,
  input wire logic loc_valid,
  input wire logic loc_write,
  output logic loc_ready,
  output logic loc_rsp_valid,
  output logic loc_rsp_write,
  output logic loc_rsp_err,
  output logic [31:0] loc_rsp_data
);
  logic pend_q, wr_q;
  logic [7:0] cnt_q, tid_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {req_ready, rsp_valid, pend_q, wr_q} <= 4'h0;
      {cnt_q, tid_q, rsp_tid, rsp_ttype, rsp_status} <= 32'h0;
      rsp_data <= 32'h0;
    end else begin
      req_ready <= req_valid && !req_ready;
      rsp_valid <= 1'b0;
      // Idle lines keep moving so a stale value is never mistaken
      rsp_data <= ~rsp_data;
      rsp_tid <= ~rsp_tid;
      if (req_valid && req_ready) begin
        {pend_q, cnt_q, tid_q} <= {1'b1, far_lag, req_tid};
        wr_q <= req_ttype == mrt_pkg::TT_WR_REQ;
      end else if (pend_q && cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end else if (pend_q) begin
        {pend_q, rsp_valid} <= 2'h1;
        rsp_tid <= far_bad ? ~tid_q : tid_q;
        rsp_ttype <= wr_q ? mrt_pkg::TT_WR_RSP : mrt_pkg::TT_RD_RSP;
        rsp_status <= mrt_pkg::STAT_DONE;
        rsp_data <= {24'h5A0000, tid_q};
      end
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {loc_ready, loc_rsp_valid, loc_rsp_write, loc_rsp_err} <= 4'h0;
      loc_rsp_data <= 32'h0;
    end else begin
      loc_ready <= loc_valid && !loc_ready;
      loc_rsp_valid <= loc_valid && loc_ready;
      loc_rsp_write <= loc_write;
      loc_rsp_err <= 1'b0;
      loc_rsp_data <= loc_valid && loc_ready ? 32'h0C0FFEE0 : ~loc_rsp_data;
    end
  end
endmodule : mrt_far_end
`default_nettype wire

// ==== mrt_pkg.sv ====
/*
  Package for the maintenance request tracker: field layouts, reset values
  and the bus widths and type and status codes shared by its modules.
  Assumes nothing of its surroundings.
*/
package mrt_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned HOP_MSB = 31;
  localparam int unsigned HOP_LSB = 24;
  localparam int unsigned OFS_MSB = 23;
  localparam int unsigned OFS_LSB = 2;
  localparam logic [7:0] TID_RST = 8'h00;
  localparam logic [7:0] HOP_LOCAL = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] TT_RD_REQ = 4'h0;
  localparam logic [3:0] TT_WR_REQ = 4'h1;
  localparam logic [3:0] TT_RD_RSP = 4'h2;
  localparam logic [3:0] TT_WR_RSP = 4'h3;
  localparam logic [3:0] STAT_DONE = 4'h0;
  localparam logic [7:0] INFO_TID_RST = 8'h00;
endpackage : mrt_pkg

// ==== testbench.sv ====
/*
  Self-checking bench for the maintenance request tracker.
  Assumes the far side model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk, rst, maint_rst, s_awvalid, s_wvalid, s_bready, s_arvalid;
  logic s_rready, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic loc_valid, loc_write, loc_ready, loc_rsp_valid, loc_rsp_write;
  logic loc_rsp_err, req_valid, req_crf, req_ready, rsp_valid, info_crf;
  logic info_tid_we, far_bad, ok, seen;
  logic [1:0] s_bresp, s_rresp, req_prio, info_prio, r;
  logic [3:0] s_wstrb, req_ttype, rsp_ttype, rsp_status;
  logic [7:0] req_tid, req_hop, rsp_tid, info_tid_wdata, info_tid, far_lag;
  logic [15:0] req_src_id, req_dst_id, base_dev_id, info_dst_id;
  logic [23:0] loc_addr, req_offset, link_timeout_reg, link_timeout;
  logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata, loc_wdata, d;
  logic [31:0] loc_rsp_data, req_data, rsp_data;
  int errors, checked;
  maint_request_tracker maint_request_tracker_i (.*);
  mrt_far_end mrt_far_end_i (.*);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic end_of_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Answer wait is bounded by lim, so it doubles as the user timeout
  task automatic rd(input logic [31:0] a, input int lim, input bit must);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    for (int n = 0; n < 20 && s_arready !== 1'b1; n++) @(posedge ref_clk);
    if (s_arready !== 1'b1) begin
      errors++;
      end_of_test();
    end
    s_arvalid <= 1'b0;
    s_rready <= 1'b1;
    for (int n = 0; n < lim && s_rvalid !== 1'b1; n++) @(posedge ref_clk);
    ok = s_rvalid === 1'b1;
    d = s_rdata;
    s_rready <= 1'b0;
    @(posedge ref_clk);
    if (!ok && must) begin
      errors++;
      end_of_test();
    end
  endtask : rd
  task automatic wr(input logic [31:0] a);
    {s_awaddr, s_wdata, s_awvalid, s_wvalid} <= {a, ~a, 2'h3};
    for (int n = 0; n < 20 && s_awready !== 1'b1; n++) @(posedge ref_clk);
    if (s_awready !== 1'b1) begin
      errors++;
      end_of_test();
    end
    {s_awvalid, s_wvalid, s_bready} <= 3'h1;
    for (int n = 0; n < 40 && s_bvalid !== 1'b1; n++) @(posedge ref_clk);
    if (s_bvalid !== 1'b1) begin
      errors++;
      end_of_test();
    end
    r = s_bresp;
    s_bready <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic mrst_pulse;
    maint_rst <= 1'b1;
    @(posedge ref_clk);
    maint_rst <= 1'b0;
    @(posedge ref_clk);
  endtask : mrst_pulse
  task automatic sc_remote;
    rd(32'h01000063, 40, 1'b1);
    chk("read tid 0", 32'h5A000000, d);
    rd(32'h05000010, 40, 1'b1);
    chk("read tid 1", 32'h5A000001, d);
    wr(32'h02000006);
    chk("remote bresp", {30'h0, mrt_pkg::RESP_OKAY}, {30'h0, r});
    chk("next tid", 32'h00000003, {24'h0, info_tid});
    // Packet fields stay put until the next remote request
    chk("req type", {28'h0, mrt_pkg::TT_WR_REQ}, {28'h0, req_ttype});
    chk("req data", 32'hFDFFFFF9, req_data);
    chk("req offset", 32'h00000004, {8'h0, req_offset});
    chk("req hop", 32'h00000001, {24'h0, req_hop});
    chk("src id", 32'h00000012, {16'h0, req_src_id});
    chk("dst id", 32'h00000034, {16'h0, req_dst_id});
    chk("prio", 32'h00000001, {30'h0, req_prio});
    {info_tid_wdata, info_tid_we} <= {8'h40, 1'b1};
    @(posedge ref_clk);
    info_tid_we <= 1'b0;
    rd(32'h01000000, 40, 1'b1);
    chk("overwritten tid", 32'h5A000040, d);
  endtask : sc_remote
  task automatic sc_local;
    rd(32'h00000060, 40, 1'b1);
    chk("local read", 32'h0C0FFEE0, d);
    wr(32'h00000066);
    chk("local bresp", {30'h0, mrt_pkg::RESP_OKAY}, {30'h0, r});
    chk("local addr", 32'h00000064, {8'h0, loc_addr});
    chk("local wdata", 32'hFFFFFF99, loc_wdata);
    chk("local write", 32'h00000001, {31'h0, loc_write});
  endtask : sc_local
  task automatic sc_timeout;
    link_timeout_reg <= 24'h000018;
    repeat (2) @(posedge ref_clk);
    chk("timeout value", 32'h00000018, {8'h0, link_timeout});
    far_bad <= 1'b1;
    rd(32'h03000008, int'(link_timeout), 1'b0);
    chk("mismatch dropped", 32'h0, {31'h0, ok});
    far_bad <= 1'b0;
    mrst_pulse();
    rd(32'h03000008, 40, 1'b1);
    chk("after cancel", 32'h5A000042, d);
  endtask : sc_timeout
  task automatic sc_late;
    far_lag <= 8'h1E;
    rd(32'h01000020, 10, 1'b0);
    mrst_pulse();
    far_lag <= 8'h00;
    seen = 1'b0;
    repeat (40) begin
      @(posedge ref_clk);
      seen = seen | (s_rvalid !== 1'b0);
    end
    chk("late dropped", 32'h0, {31'h0, seen});
    rd(32'h01000020, 40, 1'b1);
    chk("read after late", 32'h5A000044, d);
  endtask : sc_late
  initial begin
    errors = 0;
    checked = 0;
    {rst, maint_rst, s_awvalid, s_wvalid, s_bready, s_arvalid} = 6'h20;
    {s_rready, info_tid_we, far_bad, info_crf} = 4'h0;
    {s_awaddr, s_wdata, s_araddr} = 96'h0;
    {info_tid_wdata, far_lag, link_timeout_reg} = 40'h0;
    {base_dev_id, info_dst_id, info_prio} = 34'h0004800D1;
    s_wstrb = 4'hF;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    sc_remote();
    sc_local();
    sc_timeout();
    sc_late();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
